// *** logic/gpio_cfg_reg.sv ***
// one masked configuration register with synchronous reset
`include "gpio_consts.svh"
module gpio_cfg_reg #(
  parameter gpio_pkg::gpio_byte_t MASK = `GPIO_BYTE_ONES,
  parameter gpio_pkg::gpio_byte_t RST = `GPIO_CFG_RST
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wrEn,
  input wire gpio_pkg::gpio_byte_t wrData,
  output gpio_pkg::gpio_byte_t value
);
  gpio_pkg::gpio_byte_t reg_q;

  // unwritable bits stay zero so reads of them return zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_q <= RST & MASK;
    end else if (wrEn) begin
      reg_q <= wrData & MASK;
    end
  end

  assign value = reg_q;
endmodule : gpio_cfg_reg

// *** logic/gpio_consts.svh ***
// constants for the general purpose port block: addresses, masks, fields, codes
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// register byte addresses
`define GPIO_ADDR_PORTONE_DATA 16'h00e1
`define GPIO_ADDR_PORTONE_DIR 16'h00e3
`define GPIO_ADDR_PORTTHREE_DATA 16'h00e5
`define GPIO_ADDR_PORTTHREE_DIR 16'h00e7
`define GPIO_ADDR_PORTFOUR_DATA 16'h00e8
`define GPIO_ADDR_PORTFOUR_DIR 16'h00ea
`define GPIO_ADDR_PULLUP_LOW 16'h00f0
`define GPIO_ADDR_PULLUP_HIGH 16'h00f1
`define GPIO_ADDR_FIRST_DRIVE 16'h00f2
`define GPIO_ADDR_DRIVE_LOW 16'h00f3
`define GPIO_ADDR_DRIVE_HIGH 16'h00f4
`define GPIO_ADDR_THRESH_LOW 16'h00f5
`define GPIO_ADDR_THRESH_HIGH 16'h00f6

// implemented pin masks per port, plus the crystal and converter pins of the fourth port
`define GPIO_PORTONE_IMPL 8'hff
`define GPIO_PORTTHREE_IMPL 8'hb8
`define GPIO_PORTFOUR_IMPL 8'he0
`define GPIO_PORTFOUR_OSC_MASK 8'hc0
`define GPIO_PORTFOUR_CONV_MASK 8'h04

// pin groups used by pull-up and drive selection
`define GPIO_GRP_ONE_LOW 8'h0f
`define GPIO_GRP_ONE_HIGH 8'hf0
`define GPIO_GRP_THREE_SINGLE 8'h08
`define GPIO_GRP_THREE_TRIPLE 8'hb0
`define GPIO_GRP_FOUR_TRIPLE 8'he0

// reset values and whole-byte constants
`define GPIO_DIR_RST 8'h00
`define GPIO_CFG_RST 8'h00
`define GPIO_BYTE_ZERO 8'h00
`define GPIO_BYTE_ONES 8'hff

// writable bits of the configuration registers
`define GPIO_PULLUP_LOW_MASK 8'h0f
`define GPIO_PULLUP_HIGH_MASK 8'h01
`define GPIO_DRIVE_LOW_MASK 8'h03
`define GPIO_DRIVE_HIGH_MASK 8'h01
`define GPIO_THRESH_LOW_MASK 8'h0f
`define GPIO_THRESH_HIGH_MASK 8'h03

// field positions
`define GPIO_PU_ONE_LOW 0
`define GPIO_PU_ONE_HIGH 1
`define GPIO_PU_THREE_SINGLE 2
`define GPIO_PU_THREE_TRIPLE 3
`define GPIO_PU_FOUR_TRIPLE 0
`define GPIO_DRV_THREE_SINGLE 0
`define GPIO_DRV_THREE_TRIPLE 1
`define GPIO_DRV_FOUR_TRIPLE 0
`define GPIO_THR_ONE_LSB 0
`define GPIO_THR_THREE_LSB 2
`define GPIO_THR_FOUR_LSB 0

// input threshold codes
`define GPIO_THR_035 2'h0
`define GPIO_THR_050 2'h1
`define GPIO_THR_070 2'h2

`endif

// *** logic/gpio_pkg.sv ***
// types shared by the general purpose port block
package gpio_pkg;
  typedef logic [7:0] gpio_byte_t;
  typedef logic [1:0] gpio_thr_t;
endpackage : gpio_pkg

// *** logic/gpio_port_slice.sv ***
// one eight-pin port: direction register, output latch and pin read path
`include "gpio_consts.svh"
module gpio_port_slice #(
  parameter gpio_pkg::gpio_byte_t IMPL = `GPIO_BYTE_ONES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic dirWe,
  input wire logic dataWe,
  input wire gpio_pkg::gpio_byte_t wrData,
  input wire gpio_pkg::gpio_byte_t avail,
  input wire gpio_pkg::gpio_byte_t pinIn,
  input wire gpio_pkg::gpio_byte_t periphOe,
  input wire gpio_pkg::gpio_byte_t periphOut,
  output gpio_pkg::gpio_byte_t dirValue,
  output gpio_pkg::gpio_byte_t readData,
  output gpio_pkg::gpio_byte_t pinOut,
  output gpio_pkg::gpio_byte_t pinOe
);
  gpio_pkg::gpio_byte_t dir_q;
  gpio_pkg::gpio_byte_t latch_q;
  gpio_pkg::gpio_byte_t useMask;

  // direction starts as input everywhere; missing pins keep zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dir_q <= `GPIO_DIR_RST;
    end else if (dirWe) begin
      dir_q <= wrData & IMPL;
    end
  end

  // latch has no reset: its content is undefined until written
  always_ff @(posedge mclk) begin
    if (dataWe) begin
      latch_q <= wrData & IMPL;
    end
  end

  assign useMask = IMPL & avail;
  assign dirValue = dir_q;
  // peripheral output wins over the direction bit
  assign pinOe = (dir_q | periphOe) & useMask;
  // undriven pins show zero so no unknown leaves the block on a released pin
  assign pinOut = pinOe & ((periphOe & periphOut) | (~periphOe & latch_q));
  // output mode reads the latch, input mode reads the pin
  assign readData = ((dir_q & latch_q) | (~dir_q & pinIn)) & useMask;
endmodule : gpio_port_slice

// *** logic/gpio_ports.sv ***
// general purpose port block top: register port, three ports, pin options
`include "gpio_consts.svh"
module gpio_ports #(
  parameter int ADDR_W = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] busAddr,
  input wire gpio_pkg::gpio_byte_t busWrData,
  input wire logic busWrStb,
  input wire logic busRdStb,
  output gpio_pkg::gpio_byte_t busRdData,
  input wire gpio_pkg::gpio_byte_t portOnePinIn,
  output gpio_pkg::gpio_byte_t portOnePinOut,
  output gpio_pkg::gpio_byte_t portOnePinOe,
  input wire gpio_pkg::gpio_byte_t portThreePinIn,
  output gpio_pkg::gpio_byte_t portThreePinOut,
  output gpio_pkg::gpio_byte_t portThreePinOe,
  input wire gpio_pkg::gpio_byte_t portFourPinIn,
  output gpio_pkg::gpio_byte_t portFourPinOut,
  output gpio_pkg::gpio_byte_t portFourPinOe,
  input wire gpio_pkg::gpio_byte_t portOnePeriphOe,
  input wire gpio_pkg::gpio_byte_t portOnePeriphOut,
  input wire gpio_pkg::gpio_byte_t portThreePeriphOe,
  input wire gpio_pkg::gpio_byte_t portThreePeriphOut,
  input wire gpio_pkg::gpio_byte_t portFourPeriphOe,
  input wire gpio_pkg::gpio_byte_t portFourPeriphOut,
  input wire logic mainOscInUse,
  input wire logic subOscInUse,
  input wire logic converterInUse,
  output gpio_pkg::gpio_byte_t portOnePullUp,
  output gpio_pkg::gpio_byte_t portThreePullUp,
  output gpio_pkg::gpio_byte_t portFourPullUp,
  output gpio_pkg::gpio_byte_t portOneDriveHigh,
  output gpio_pkg::gpio_byte_t portThreeDriveHigh,
  output gpio_pkg::gpio_byte_t portFourDriveHigh,
  output gpio_pkg::gpio_thr_t portOneThresh,
  output gpio_pkg::gpio_thr_t portThreeThresh,
  output gpio_pkg::gpio_thr_t portFourThresh
);

  // address constants sized to the bus
  localparam logic [ADDR_W-1:0] A_ONE_DATA = ADDR_W'(`GPIO_ADDR_PORTONE_DATA);
  localparam logic [ADDR_W-1:0] A_ONE_DIR = ADDR_W'(`GPIO_ADDR_PORTONE_DIR);
  localparam logic [ADDR_W-1:0] A_THREE_DATA = ADDR_W'(`GPIO_ADDR_PORTTHREE_DATA);
  localparam logic [ADDR_W-1:0] A_THREE_DIR = ADDR_W'(`GPIO_ADDR_PORTTHREE_DIR);
  localparam logic [ADDR_W-1:0] A_FOUR_DATA = ADDR_W'(`GPIO_ADDR_PORTFOUR_DATA);
  localparam logic [ADDR_W-1:0] A_FOUR_DIR = ADDR_W'(`GPIO_ADDR_PORTFOUR_DIR);
  localparam logic [ADDR_W-1:0] A_PU_LOW = ADDR_W'(`GPIO_ADDR_PULLUP_LOW);
  localparam logic [ADDR_W-1:0] A_PU_HIGH = ADDR_W'(`GPIO_ADDR_PULLUP_HIGH);
  localparam logic [ADDR_W-1:0] A_DRV_FIRST = ADDR_W'(`GPIO_ADDR_FIRST_DRIVE);
  localparam logic [ADDR_W-1:0] A_DRV_LOW = ADDR_W'(`GPIO_ADDR_DRIVE_LOW);
  localparam logic [ADDR_W-1:0] A_DRV_HIGH = ADDR_W'(`GPIO_ADDR_DRIVE_HIGH);
  localparam logic [ADDR_W-1:0] A_THR_LOW = ADDR_W'(`GPIO_ADDR_THRESH_LOW);
  localparam logic [ADDR_W-1:0] A_THR_HIGH = ADDR_W'(`GPIO_ADDR_THRESH_HIGH);

  // address decode
  wire logic selOneData = (busAddr == A_ONE_DATA);
  wire logic selOneDir = (busAddr == A_ONE_DIR);
  wire logic selThreeData = (busAddr == A_THREE_DATA);
  wire logic selThreeDir = (busAddr == A_THREE_DIR);
  wire logic selFourData = (busAddr == A_FOUR_DATA);
  wire logic selFourDir = (busAddr == A_FOUR_DIR);
  wire logic selPuLow = (busAddr == A_PU_LOW);
  wire logic selPuHigh = (busAddr == A_PU_HIGH);
  wire logic selDrvFirst = (busAddr == A_DRV_FIRST);
  wire logic selDrvLow = (busAddr == A_DRV_LOW);
  wire logic selDrvHigh = (busAddr == A_DRV_HIGH);
  wire logic selThrLow = (busAddr == A_THR_LOW);
  wire logic selThrHigh = (busAddr == A_THR_HIGH);

  // write enables, one per register
  wire logic weOneData = busWrStb & selOneData;
  wire logic weOneDir = busWrStb & selOneDir;
  wire logic weThreeData = busWrStb & selThreeData;
  wire logic weThreeDir = busWrStb & selThreeDir;
  wire logic weFourData = busWrStb & selFourData;
  wire logic weFourDir = busWrStb & selFourDir;
  wire logic wePuLow = busWrStb & selPuLow;
  wire logic wePuHigh = busWrStb & selPuHigh;
  wire logic weDrvFirst = busWrStb & selDrvFirst;
  wire logic weDrvLow = busWrStb & selDrvLow;
  wire logic weDrvHigh = busWrStb & selDrvHigh;
  wire logic weThrLow = busWrStb & selThrLow;
  wire logic weThrHigh = busWrStb & selThrHigh;

  // pin availability: the crystal pins leave the port while either oscillator runs
  wire logic oscBusy = mainOscInUse | subOscInUse;
  wire gpio_pkg::gpio_byte_t fourAvail = oscBusy ?
    ~`GPIO_PORTFOUR_OSC_MASK : `GPIO_BYTE_ONES;
  // the converter pin has no driver and reads only while the converter is idle
  wire gpio_pkg::gpio_byte_t convRead = converterInUse ? `GPIO_BYTE_ZERO :
    (portFourPinIn & `GPIO_PORTFOUR_CONV_MASK);

  gpio_pkg::gpio_byte_t oneDir;
  gpio_pkg::gpio_byte_t oneRead;
  gpio_pkg::gpio_byte_t threeDir;
  gpio_pkg::gpio_byte_t threeRead;
  gpio_pkg::gpio_byte_t fourDir;
  gpio_pkg::gpio_byte_t fourRead;
  gpio_pkg::gpio_byte_t puLow;
  gpio_pkg::gpio_byte_t puHigh;
  gpio_pkg::gpio_byte_t drvFirst;
  gpio_pkg::gpio_byte_t drvLow;
  gpio_pkg::gpio_byte_t drvHigh;
  gpio_pkg::gpio_byte_t thrLow;
  gpio_pkg::gpio_byte_t thrHigh;

  // first port: all eight pins implemented
  gpio_port_slice #(
    .IMPL(`GPIO_PORTONE_IMPL)
  ) uPortOne (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .dirWe(weOneDir),
    .dataWe(weOneData),
    .wrData(busWrData),
    .avail(`GPIO_BYTE_ONES),
    .pinIn(portOnePinIn),
    .periphOe(portOnePeriphOe),
    .periphOut(portOnePeriphOut),
    .dirValue(oneDir),
    .readData(oneRead),
    .pinOut(portOnePinOut),
    .pinOe(portOnePinOe)
  );

  // third port: reserved positions masked inside the slice
  gpio_port_slice #(
    .IMPL(`GPIO_PORTTHREE_IMPL)
  ) uPortThree (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .dirWe(weThreeDir),
    .dataWe(weThreeData),
    .wrData(busWrData),
    .avail(`GPIO_BYTE_ONES),
    .pinIn(portThreePinIn),
    .periphOe(portThreePeriphOe),
    .periphOut(portThreePeriphOut),
    .dirValue(threeDir),
    .readData(threeRead),
    .pinOut(portThreePinOut),
    .pinOe(portThreePinOe)
  );

  // fourth port: only the top three pins have a latch and a driver
  gpio_port_slice #(
    .IMPL(`GPIO_PORTFOUR_IMPL)
  ) uPortFour (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .dirWe(weFourDir),
    .dataWe(weFourData),
    .wrData(busWrData),
    .avail(fourAvail),
    .pinIn(portFourPinIn),
    .periphOe(portFourPeriphOe),
    .periphOut(portFourPeriphOut),
    .dirValue(fourDir),
    .readData(fourRead),
    .pinOut(portFourPinOut),
    .pinOe(portFourPinOe)
  );

  // pull-up selection registers
  gpio_cfg_reg #(
    .MASK(`GPIO_PULLUP_LOW_MASK),
    .RST(`GPIO_CFG_RST)
  ) uPuLow (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wrEn(wePuLow),
    .wrData(busWrData),
    .value(puLow)
  );

  gpio_cfg_reg #(
    .MASK(`GPIO_PULLUP_HIGH_MASK),
    .RST(`GPIO_CFG_RST)
  ) uPuHigh (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wrEn(wePuHigh),
    .wrData(busWrData),
    .value(puHigh)
  );

  // drive strength registers
  gpio_cfg_reg #(
    .MASK(`GPIO_BYTE_ONES),
    .RST(`GPIO_CFG_RST)
  ) uDrvFirst (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wrEn(weDrvFirst),
    .wrData(busWrData),
    .value(drvFirst)
  );

  gpio_cfg_reg #(
    .MASK(`GPIO_DRIVE_LOW_MASK),
    .RST(`GPIO_CFG_RST)
  ) uDrvLow (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wrEn(weDrvLow),
    .wrData(busWrData),
    .value(drvLow)
  );

  gpio_cfg_reg #(
    .MASK(`GPIO_DRIVE_HIGH_MASK),
    .RST(`GPIO_CFG_RST)
  ) uDrvHigh (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wrEn(weDrvHigh),
    .wrData(busWrData),
    .value(drvHigh)
  );

  // input threshold registers
  gpio_cfg_reg #(
    .MASK(`GPIO_THRESH_LOW_MASK),
    .RST(`GPIO_CFG_RST)
  ) uThrLow (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wrEn(weThrLow),
    .wrData(busWrData),
    .value(thrLow)
  );

  gpio_cfg_reg #(
    .MASK(`GPIO_THRESH_HIGH_MASK),
    .RST(`GPIO_CFG_RST)
  ) uThrHigh (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wrEn(weThrHigh),
    .wrData(busWrData),
    .value(thrHigh)
  );

  // pull-up group enables spread to pins
  wire gpio_pkg::gpio_byte_t puOneGrp =
    ({8{puLow[`GPIO_PU_ONE_LOW]}} & `GPIO_GRP_ONE_LOW) |
    ({8{puLow[`GPIO_PU_ONE_HIGH]}} & `GPIO_GRP_ONE_HIGH);
  wire gpio_pkg::gpio_byte_t puThreeGrp =
    ({8{puLow[`GPIO_PU_THREE_SINGLE]}} & `GPIO_GRP_THREE_SINGLE) |
    ({8{puLow[`GPIO_PU_THREE_TRIPLE]}} & `GPIO_GRP_THREE_TRIPLE);
  wire gpio_pkg::gpio_byte_t puFourGrp =
    {8{puHigh[`GPIO_PU_FOUR_TRIPLE]}} & `GPIO_GRP_FOUR_TRIPLE;

  // a pull-up only hangs on a pin that nobody drives; the converter pin has none
  assign portOnePullUp = puOneGrp & ~portOnePinOe & ~oneDir;
  assign portThreePullUp = puThreeGrp & ~portThreePinOe & ~threeDir;
  assign portFourPullUp = puFourGrp & ~portFourPinOe & ~fourDir & fourAvail;

  // drive strength: per bit on the first port, grouped elsewhere
  assign portOneDriveHigh = drvFirst;
  assign portThreeDriveHigh =
    ({8{drvLow[`GPIO_DRV_THREE_SINGLE]}} & `GPIO_GRP_THREE_SINGLE) |
    ({8{drvLow[`GPIO_DRV_THREE_TRIPLE]}} & `GPIO_GRP_THREE_TRIPLE);
  assign portFourDriveHigh =
    {8{drvHigh[`GPIO_DRV_FOUR_TRIPLE]}} & `GPIO_GRP_FOUR_TRIPLE;

  // threshold fields; the spare code falls back to the middle level
  // so the input buffer never sees an undefined selection
  function automatic gpio_pkg::gpio_thr_t thrSel(input gpio_pkg::gpio_thr_t code);
    if (code == `GPIO_THR_035 || code == `GPIO_THR_070) begin
      return code;
    end
    return `GPIO_THR_050;
  endfunction : thrSel

  assign portOneThresh = thrSel(thrLow[`GPIO_THR_ONE_LSB +: 2]);
  assign portThreeThresh = thrSel(thrLow[`GPIO_THR_THREE_LSB +: 2]);
  assign portFourThresh = thrSel(thrHigh[`GPIO_THR_FOUR_LSB +: 2]);

  // read selection; unmapped addresses answer zero
  gpio_pkg::gpio_byte_t rdSel;
  always_comb begin
    rdSel = `GPIO_BYTE_ZERO;
    unique case (1'b1)
      selOneData: rdSel = oneRead;
      selOneDir: rdSel = oneDir;
      selThreeData: rdSel = threeRead;
      selThreeDir: rdSel = threeDir;
      selFourData: rdSel = fourRead | convRead;
      selFourDir: rdSel = fourDir;
      selPuLow: rdSel = puLow;
      selPuHigh: rdSel = puHigh;
      selDrvFirst: rdSel = drvFirst;
      selDrvLow: rdSel = drvLow;
      selDrvHigh: rdSel = drvHigh;
      selThrLow: rdSel = thrLow;
      selThrHigh: rdSel = thrHigh;
      default: rdSel = `GPIO_BYTE_ZERO;
    endcase
  end

  // read data stands only in the cycle after the strobe, zero otherwise
  gpio_pkg::gpio_byte_t rdData_q;
  gpio_pkg::gpio_byte_t rdData_d;
  assign rdData_d = busRdStb ? rdSel : `GPIO_BYTE_ZERO;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdData_q <= `GPIO_BYTE_ZERO;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  assign busRdData = rdData_q;
endmodule : gpio_ports

// *** tb/gpio_pin_model.sv ***
// external devices on one eight-pin port: drive, sense or leave floating
module gpio_pin_model (
  input wire logic mclk,
  input wire gpio_pkg::gpio_byte_t pinOut,
  input wire gpio_pkg::gpio_byte_t pinOe,
  input wire gpio_pkg::gpio_byte_t pullUp,
  input wire gpio_pkg::gpio_byte_t extEn,
  input wire gpio_pkg::gpio_byte_t extVal,
  output gpio_pkg::gpio_byte_t pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  gpio_pkg::gpio_byte_t float_q = 8'h55;
  // a floating pin wanders every cycle so no test can lean on its level
  always_ff @(posedge mclk) begin
    float_q <= ~float_q;
  end
  // block drive wins, then external drive, then pull-up or wander
  assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal) |
    (~pinOe & ~extEn & (pullUp | float_q));
endmodule : gpio_pin_model

// *** tb/gpio_ports_monitor.sv ***
// concurrent checks on the port block's register bus and pins
`include "gpio_consts.svh"
module gpio_ports_monitor #(
  parameter int ADDR_W = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] busAddr,
  input wire gpio_pkg::gpio_byte_t busWrData,
  input wire logic busWrStb,
  input wire logic busRdStb,
  input wire gpio_pkg::gpio_byte_t busRdData,
  input wire gpio_pkg::gpio_byte_t portOnePinIn,
  input wire gpio_pkg::gpio_byte_t portOnePinOut,
  input wire gpio_pkg::gpio_byte_t portOnePinOe,
  input wire gpio_pkg::gpio_byte_t portThreePinOe,
  input wire gpio_pkg::gpio_byte_t portFourPinOe,
  input wire gpio_pkg::gpio_byte_t portOnePeriphOe,
  input wire gpio_pkg::gpio_byte_t portOnePeriphOut,
  input wire logic mainOscInUse,
  input wire logic subOscInUse,
  input wire gpio_pkg::gpio_byte_t portOnePullUp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // single-cycle strobes aimed at one register
  sequence rdAt(a);
    busRdStb && busAddr == a;
  endsequence
  sequence wrAt(a);
    busWrStb && busAddr == a;
  endsequence
  AST_DIR_OE: assert property (wrAt(`GPIO_ADDR_PORTONE_DIR) |=>
    portOnePinOe == ($past(busWrData) | portOnePeriphOe)) else $error("direction not at pins");
  AST_LATCH_DRIVE: assert property (wrAt(`GPIO_ADDR_PORTONE_DATA) ##0
    (portOnePinOe == 8'hff && portOnePeriphOe == 8'h00) |=>
    portOnePeriphOe != 8'h00 || portOnePinOut == $past(busWrData)) else $error("latch not driven");
  AST_PERIPH_WIN: assert property ((portOnePinOe & portOnePeriphOe) == portOnePeriphOe &&
    (portOnePinOut & portOnePeriphOe) == (portOnePeriphOut & portOnePeriphOe))
    else $error("peripheral output lost");
  AST_IN_READ: assert property (rdAt(`GPIO_ADDR_PORTONE_DATA) ##0 (portOnePinOe == 8'h00)
    |=> busRdData == $past(portOnePinIn)) else $error("input read not pin level");
  AST_P3_READ: assert property (rdAt(`GPIO_ADDR_PORTTHREE_DATA) or
    rdAt(`GPIO_ADDR_PORTTHREE_DIR) |=> (busRdData & 8'h47) == 8'h00) else $error("port3 reserved");
  AST_P4_DIR: assert property (rdAt(`GPIO_ADDR_PORTFOUR_DIR) |=>
    (busRdData & 8'h1f) == 8'h00) else $error("port4 direction low bits");
  AST_P4_DATA: assert property (rdAt(`GPIO_ADDR_PORTFOUR_DATA) |=>
    (busRdData & 8'h1b) == 8'h00) else $error("port4 data low bits");
  AST_P3_NODRV: assert property ((portThreePinOe & 8'h47) == 8'h00)
    else $error("port3 reserved pin driven");
  AST_P4_NODRV: assert property ((portFourPinOe & 8'h1f) == 8'h00)
    else $error("port4 input-only pin driven");
  AST_OSC_GATE: assert property (mainOscInUse || subOscInUse |->
    (portFourPinOe & 8'hc0) == 8'h00) else $error("crystal pin driven");
  AST_PULLUP: assert property ((portOnePullUp & portOnePinOe) == 8'h00)
    else $error("pull-up on output");
  AST_RST_DIR: assert property ($fell(sys_rst) |-> portOnePinOe == portOnePeriphOe)
    else $error("direction not cleared by reset");
endmodule : gpio_ports_monitor

bind gpio_ports gpio_ports_monitor #(.ADDR_W(ADDR_W)) i_gpio_ports_monitor (
  .mclk(mclk), .sys_rst(sys_rst), .busAddr(busAddr), .busWrData(busWrData),
  .busWrStb(busWrStb), .busRdStb(busRdStb), .busRdData(busRdData),
  .portOnePinIn(portOnePinIn), .portOnePinOut(portOnePinOut), .portOnePinOe(portOnePinOe),
  .portThreePinOe(portThreePinOe), .portFourPinOe(portFourPinOe),
  .portOnePeriphOe(portOnePeriphOe), .portOnePeriphOut(portOnePeriphOut),
  .mainOscInUse(mainOscInUse), .subOscInUse(subOscInUse), .portOnePullUp(portOnePullUp));

// *** tb/gpio_ports_test.sv ***
// self-checking bench for the general purpose port block
`include "gpio_consts.svh"
module gpio_ports_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] busAddr = 16'h0000;
  logic busWrStb = 1'b0;
  logic busRdStb = 1'b0;
  logic mainOsc = 1'b0;
  logic subOsc = 1'b0;
  logic convUse = 1'b0;
  gpio_pkg::gpio_byte_t busWrData = 8'h00, perOe = 8'h00, perOut = 8'h00, zeroB = 8'h00;
  gpio_pkg::gpio_byte_t rdData, in1, out1, oe1, in3, out3, oe3, in4, out4, oe4;
  gpio_pkg::gpio_byte_t pu1, pu3, pu4, dh1, dh3, dh4, thrExp;
  // level the outside world puts on the first port; changed mid-run to test reads
  gpio_pkg::gpio_byte_t ext1 = 8'hc3;
  gpio_pkg::gpio_thr_t th1, th3, th4;
  gpio_pkg::gpio_byte_t cfgMask [7] = '{8'h0f, 8'h01, 8'hff, 8'h03, 8'h01, 8'h0f, 8'h03};
  int errors = 0;
  int tests_run = 0;

  gpio_ports i_gpio_ports (.mclk(mclk), .sys_rst(sys_rst), .busAddr(busAddr),
    .busWrData(busWrData), .busWrStb(busWrStb), .busRdStb(busRdStb), .busRdData(rdData),
    .portOnePinIn(in1), .portOnePinOut(out1), .portOnePinOe(oe1),
    .portThreePinIn(in3), .portThreePinOut(out3), .portThreePinOe(oe3),
    .portFourPinIn(in4), .portFourPinOut(out4), .portFourPinOe(oe4),
    .portOnePeriphOe(perOe), .portOnePeriphOut(perOut), .portThreePeriphOe(zeroB),
    .portThreePeriphOut(zeroB), .portFourPeriphOe(zeroB), .portFourPeriphOut(zeroB),
    .mainOscInUse(mainOsc), .subOscInUse(subOsc), .converterInUse(convUse),
    .portOnePullUp(pu1), .portThreePullUp(pu3), .portFourPullUp(pu4),
    .portOneDriveHigh(dh1), .portThreeDriveHigh(dh3), .portFourDriveHigh(dh4),
    .portOneThresh(th1), .portThreeThresh(th3), .portFourThresh(th4));
  // external drivers: every pin the block releases is held at a known level
  gpio_pin_model i_gpio_pin_model_1 (.mclk(mclk), .pinOut(out1), .pinOe(oe1), .pullUp(pu1),
    .extEn(8'hff), .extVal(ext1), .pinIn(in1));
  gpio_pin_model i_gpio_pin_model_3 (.mclk(mclk), .pinOut(out3), .pinOe(oe3), .pullUp(pu3),
    .extEn(8'hff), .extVal(8'h00), .pinIn(in3));
  gpio_pin_model i_gpio_pin_model_4 (.mclk(mclk), .pinOut(out4), .pinOe(oe4), .pullUp(pu4),
    .extEn(8'hff), .extVal(8'h04), .pinIn(in4));

  initial begin
    forever #4 mclk = ~mclk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // write: one strobe cycle, result visible once the task returns
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    busWrStb <= 1'b1;
    busAddr <= a;
    busWrData <= d;
    @(posedge mclk);
    busWrStb <= 1'b0;
    #1;
  endtask : wr

  // read: data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string what);
    @(posedge mclk);
    busRdStb <= 1'b1;
    busAddr <= a;
    @(posedge mclk);
    busRdStb <= 1'b0;
    #1;
    check(rdData, e, what);
  endtask : rd

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  initial begin
    #200000;
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    results();
  end

  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(`GPIO_ADDR_PORTONE_DIR, 8'h00, "dir1 reset");
    rd(`GPIO_ADDR_PORTFOUR_DIR, 8'h00, "dir4 reset");
    check(oe1, 8'h00, "oe1 reset");
    rd(`GPIO_ADDR_PORTONE_DATA, 8'hc3, "input pins");
    rd(16'h00e2, 8'h00, "unmapped");
    for (int i = 0; i < 7; i++) begin
      rd(16'h00f0 + 16'(i), 8'h00, "cfg reset");
      wr(16'h00f0 + 16'(i), 8'hff);
      rd(16'h00f0 + 16'(i), cfgMask[i], "cfg mask");
    end
    $display("test reset and config done");
    wr(`GPIO_ADDR_PORTONE_DATA, 8'h5a);
    check(oe1, 8'h00, "latch write in input");
    wr(`GPIO_ADDR_PORTONE_DIR, 8'h0f);
    check(oe1, 8'h0f, "per-bit direction");
    check(out1, 8'h0a, "latch at pins");
    rd(`GPIO_ADDR_PORTONE_DATA, 8'hca, "mixed read");
    check(pu1, 8'hf0, "pull-up inputs only");
    wr(`GPIO_ADDR_FIRST_DRIVE, 8'ha5);
    check(dh1, 8'ha5, "port1 drive");
    wr(`GPIO_ADDR_DRIVE_LOW, 8'h02);
    check(dh3, 8'hb0, "port3 group drive");
    check(dh4, 8'he0, "port4 group drive");
    // the spare code 3 must fall back to the middle level
    for (int c = 0; c < 4; c++) begin
      thrExp = (c == 3) ? {6'h00, `GPIO_THR_050} : 8'(c);
      wr(`GPIO_ADDR_THRESH_LOW, 8'(c * 5));
      wr(`GPIO_ADDR_THRESH_HIGH, 8'(c));
      check({6'h00, th1}, thrExp, "thr1");
      check({6'h00, th3}, thrExp, "thr3");
      check({6'h00, th4}, thrExp, "thr4");
    end
    $display("test direction and options done");
    wr(`GPIO_ADDR_PORTONE_DIR, 8'hff);
    wr(`GPIO_ADDR_PORTONE_DATA, 8'h3c);
    check(out1, 8'h3c, "output levels");
    rd(`GPIO_ADDR_PORTONE_DATA, 8'h3c, "latch read");
    @(posedge mclk);
    perOe <= 8'hf0;
    perOut <= 8'ha0;
    wr(`GPIO_ADDR_PORTONE_DIR, 8'h0f);
    check(oe1, 8'hff, "periph enable");
    check(out1, 8'hac, "periph value");
    rd(`GPIO_ADDR_PORTONE_DATA, 8'hac, "periph pin read");
    check(pu3, 8'hb8, "port3 pull-up groups");
    check(pu4, 8'he0, "port4 pull-up group");
    @(posedge mclk);
    perOe <= 8'h00;
    $display("test peripheral done");
    wr(`GPIO_ADDR_PORTTHREE_DIR, 8'hff);
    rd(`GPIO_ADDR_PORTTHREE_DIR, 8'hb8, "dir3 reserved");
    check(oe3, 8'hb8, "oe3");
    wr(`GPIO_ADDR_PORTTHREE_DATA, 8'hff);
    rd(`GPIO_ADDR_PORTTHREE_DATA, 8'hb8, "data3 reserved");
    check(out3, 8'hb8, "port3 drives latch");
    check(pu3, 8'h00, "port3 pull-up off on outputs");
    wr(`GPIO_ADDR_PORTFOUR_DIR, 8'hff);
    rd(`GPIO_ADDR_PORTFOUR_DIR, 8'he0, "dir4 low bits");
    wr(`GPIO_ADDR_PORTFOUR_DATA, 8'hff);
    rd(`GPIO_ADDR_PORTFOUR_DATA, 8'he4, "data4 with input pin");
    check(out4, 8'he0, "port4 drives latch");
    @(posedge mclk);
    convUse <= 1'b1;
    rd(`GPIO_ADDR_PORTFOUR_DATA, 8'he0, "converter owns pin");
    @(posedge mclk);
    convUse <= 1'b0;
    mainOsc <= 1'b1;
    rd(`GPIO_ADDR_PORTFOUR_DATA, 8'h24, "main oscillator");
    check(oe4, 8'h20, "oe4 main");
    @(posedge mclk);
    mainOsc <= 1'b0;
    subOsc <= 1'b1;
    rd(`GPIO_ADDR_PORTFOUR_DATA, 8'h24, "sub oscillator");
    check(oe4, 8'h20, "oe4 sub");
    @(posedge mclk);
    subOsc <= 1'b0;
    $display("test ports three and four done");
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(`GPIO_ADDR_PORTONE_DIR, 8'h00, "dir1 second reset");
    check(oe1, 8'h00, "oe1 second reset");
    rd(`GPIO_ADDR_PULLUP_LOW, 8'h00, "cfg second reset");
    // a new outside level must show through on an input pin
    @(posedge mclk);
    ext1 <= 8'h96;
    rd(`GPIO_ADDR_PORTONE_DATA, 8'h96, "new pin level");
    $display("test second reset done");
    results();
  end
endmodule : gpio_ports_test
